// File: logic/ubl_pkg.sv
package ubl_pkg;
    localparam int          ADDR_W       = 4;
    localparam int          DATA_W       = 8;
    localparam int          DIV_W        = 13;
    localparam int          DIV_HI_W     = 5;
    localparam int          OSR          = 16;

    localparam logic [3:0]  OFS_BDH      = 4'h0;
    localparam logic [3:0]  OFS_BDL      = 4'h1;
    localparam logic [3:0]  OFS_C1       = 4'h2;
    localparam logic [3:0]  OFS_C2       = 4'h3;

    localparam logic [7:0]  RST_BDH      = 8'h00;
    localparam logic [7:0]  RST_BDL      = 8'h04;
    localparam logic [7:0]  RST_C1       = 8'h00;
    localparam logic [7:0]  RST_C2       = 8'h00;

    localparam int          BDH_BRK_IE   = 7;
    localparam int          BDH_EDGE_IE  = 6;
    localparam int          BDH_STOP2    = 5;
    localparam int          C1_LOOP      = 7;
    localparam int          C1_FREEZE    = 6;
    localparam int          C1_RXSRC     = 5;
    localparam int          C2_TX_EN     = 3;
    localparam int          C2_RX_EN     = 2;
endpackage : ubl_pkg

// File: logic/ubl_cfg_if.sv
`timescale 1ns/1ps
interface ubl_cfg_if;
    logic [12:0] divisor;
    logic        run;
    logic        hold;
    logic        loop_routing_select;
    logic        receiver_source_select;
    logic        tick_16x;
    logic        bit_tick;

    modport ctrl  (output divisor, run, hold, loop_routing_select, receiver_source_select,
                   input  tick_16x, bit_tick);
    modport gen   (input  divisor, run, hold, output tick_16x, bit_tick);
    modport route (input  loop_routing_select, receiver_source_select);
endinterface : ubl_cfg_if

// File: logic/ubl_rate_gen.sv
`timescale 1ns/1ps
module ubl_rate_gen #(
    parameter int DIV_W = 13,
    parameter int OSR   = 16
) (
    input  wire logic clk,
    input  wire logic reset_n,
    ubl_cfg_if.gen    cfg
);
    logic [DIV_W-1:0]       cnt_q;
    logic [$clog2(OSR)-1:0] sub_q;
    logic                   tick_q;
    logic                   bit_q;
    logic [DIV_W:0]         gap_q;
    logic                   gap_ok_q;
    logic [DIV_W-1:0]       div_seen_q;
    wire                    wrap     = cnt_q >= (cfg.divisor - DIV_W'(1));
    wire                    sub_last = sub_q == ($clog2(OSR))'(OSR - 1);

    assign cfg.tick_16x = tick_q;
    assign cfg.bit_tick = bit_q;

    // Modulo counter, one tick per divisor period
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            cnt_q  <= '0;
            sub_q  <= '0;
            tick_q <= 1'b0;
            bit_q  <= 1'b0;
        end else if (!cfg.run) begin
            cnt_q  <= '0;
            sub_q  <= '0;
            tick_q <= 1'b0;
            bit_q  <= 1'b0;
        end else if (cfg.hold) begin
            tick_q <= 1'b0;
            bit_q  <= 1'b0;
        end else begin
            cnt_q  <= wrap ? '0 : cnt_q + DIV_W'(1);
            tick_q <= wrap;
            bit_q  <= wrap && sub_last;
            sub_q  <= wrap ? sub_q + ($clog2(OSR))'(1) : sub_q;
        end
    end

    // Gap since last tick, for checking only
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            gap_q      <= '0;
            gap_ok_q   <= 1'b0;
            div_seen_q <= '0;
        end else begin
            div_seen_q <= cfg.divisor;
            gap_q      <= tick_q ? (DIV_W+1)'(1) : gap_q + (DIV_W+1)'(1);
            if (!cfg.run || cfg.hold || div_seen_q != cfg.divisor)
                gap_ok_q <= 1'b0;
            else if (tick_q)
                gap_ok_q <= 1'b1;
        end
    end

    property p_tick_period;
        @(posedge clk) disable iff (!reset_n)
        (tick_q && gap_ok_q && cfg.run && !cfg.hold) |-> gap_q == {1'b0, cfg.divisor};
    endproperty
    a_tick_period: assert property (p_tick_period) else $error("tick period wrong");

    property p_freeze;
        @(posedge clk) disable iff (!reset_n)
        (cfg.run && cfg.hold) |=> ($stable(cnt_q) && !tick_q);
    endproperty
    a_freeze: assert property (p_freeze) else $error("counter moved while frozen");
endmodule : ubl_rate_gen

// File: logic/ubl_pin_route.sv
`timescale 1ns/1ps
module ubl_pin_route (
    input  wire logic clk,
    input  wire logic reset_n,
    ubl_cfg_if.route  cfg,
    input  wire logic tx_serial,
    input  wire logic tx_drive,
    input  wire logic rxd_i,
    input  wire logic txd_i,
    output logic      txd_o,
    output logic      txd_oe,
    output logic      rx_serial
);
    wire single_wire = cfg.loop_routing_select && cfg.receiver_source_select;
    wire inner_loop  = cfg.loop_routing_select && !cfg.receiver_source_select;
    wire rx_d        = single_wire ? txd_i : (inner_loop ? tx_serial : rxd_i);
    wire oe_d        = single_wire ? tx_drive : 1'b1;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            txd_o     <= 1'b1;
            txd_oe    <= 1'b0;
            rx_serial <= 1'b1;
        end else begin
            txd_o     <= tx_serial;
            txd_oe    <= oe_d;
            rx_serial <= rx_d;
        end
    end

    property p_normal;
        @(posedge clk) disable iff (!reset_n)
        !cfg.loop_routing_select |=> (rx_serial == $past(rxd_i) && txd_oe);
    endproperty
    a_normal: assert property (p_normal) else $error("normal routing wrong");

    property p_loop;
        @(posedge clk) disable iff (!reset_n)
        inner_loop |=> (rx_serial == $past(tx_serial) && txd_oe);
    endproperty
    a_loop: assert property (p_loop) else $error("internal loop wrong");

    property p_single;
        @(posedge clk) disable iff (!reset_n)
        single_wire |=> (rx_serial == $past(txd_i) && txd_oe == $past(tx_drive));
    endproperty
    a_single: assert property (p_single) else $error("single wire wrong");
endmodule : ubl_pin_route

// File: logic/ubl_top.sv
`timescale 1ns/1ps
// Overview of operation
// - Software writes the high divisor byte first, then the low byte, which alone loads the divisor.
// - The divisor is 13 bits, its top five bits from the low bits of the high register.
// - A zero divisor turns the rate generator off completely.
// - A divisor of 1 to 8191 gives a baud rate of the bus clock over sixteen times the divisor.
// - After reset the generator stays off until receiver or transmitter enable is written to one.
// - High register bit 7 lets the break-detect flag raise an interrupt.
// - High register bit 6 lets the receive-edge flag raise an interrupt.
// - High register bit 5 picks one or two stop bits.
// - Control bit 7 routes the transmitter output back into the receiver and ignores the rx pin.
// - Control bit 6 freezes the serial clocks while the CPU waits.
// - Control bit 5 only matters under loop routing, where it decides if the tx pin is shared.
// - Loop routing with bit 5 clear is internal loopback with the rx pin unused.
// - Loop routing with bit 5 set is single-wire mode on the tx pin.
module ubl_top #(
    parameter int DIV_W = ubl_pkg::DIV_W,
    parameter int OSR   = ubl_pkg::OSR
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    input  wire logic       cpu_wait,
    input  wire logic       break_detect_flag,
    input  wire logic       rx_edge_flag,
    input  wire logic       tx_serial,
    input  wire logic       tx_drive,
    input  wire logic       rxd_i,
    input  wire logic       txd_i,
    output logic            txd_o,
    output logic            txd_oe,
    output logic            rx_serial,
    output logic            baud_tick_16x,
    output logic            baud_bit_tick,
    output logic            stop_bit_count_select,
    output logic            receiver_enable,
    output logic            transmitter_enable,
    output logic            break_irq,
    output logic            rx_edge_irq
);
    ubl_cfg_if cfg ();

    logic [7:0]       bdh_q;
    logic [DIV_W-1:0] div_q;
    logic [7:0]       c1_q;
    logic [7:0]       c2_q;
    logic             armed_q;
    logic [7:0]       rdata_q;
    logic             brk_irq_q;
    logic             edge_irq_q;

    // Address decode
    wire              wr_bdh   = reg_wr && reg_addr == ubl_pkg::OFS_BDH;
    wire              wr_bdl   = reg_wr && reg_addr == ubl_pkg::OFS_BDL;
    wire              wr_c1    = reg_wr && reg_addr == ubl_pkg::OFS_C1;
    wire              wr_c2    = reg_wr && reg_addr == ubl_pkg::OFS_C2;
    wire              arm_set  = wr_c2 &&
        (reg_wdata[ubl_pkg::C2_RX_EN] || reg_wdata[ubl_pkg::C2_TX_EN]);
    wire [DIV_W-1:0]  div_new  = {bdh_q[ubl_pkg::DIV_HI_W-1:0], reg_wdata};
    wire              div_zero = div_q == '0;

    // Read selection, unmapped reads as zero
    wire [7:0]        rd_mux   =
        (reg_addr == ubl_pkg::OFS_BDH) ? bdh_q :
        (reg_addr == ubl_pkg::OFS_BDL) ? div_q[7:0] :
        (reg_addr == ubl_pkg::OFS_C1)  ? c1_q :
        (reg_addr == ubl_pkg::OFS_C2)  ? c2_q : 8'h00;

    // Interface towards generator and router
    assign cfg.divisor                = div_q;
    assign cfg.run                    = armed_q && !div_zero;
    assign cfg.hold                   = cpu_wait && c1_q[ubl_pkg::C1_FREEZE];
    assign cfg.loop_routing_select    = c1_q[ubl_pkg::C1_LOOP];
    assign cfg.receiver_source_select = c1_q[ubl_pkg::C1_RXSRC];

    assign reg_rdata             = rdata_q;
    assign baud_tick_16x         = cfg.tick_16x;
    assign baud_bit_tick         = cfg.bit_tick;
    assign stop_bit_count_select = bdh_q[ubl_pkg::BDH_STOP2];
    assign receiver_enable       = c2_q[ubl_pkg::C2_RX_EN];
    assign transmitter_enable    = c2_q[ubl_pkg::C2_TX_EN];
    assign break_irq             = brk_irq_q;
    assign rx_edge_irq           = edge_irq_q;

    // High byte buffer and control registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bdh_q <= ubl_pkg::RST_BDH;
            c1_q  <= ubl_pkg::RST_C1;
            c2_q  <= ubl_pkg::RST_C2;
        end else begin
            if (wr_bdh)
                bdh_q <= reg_wdata;
            if (wr_c1)
                c1_q <= reg_wdata;
            if (wr_c2)
                c2_q <= reg_wdata;
        end
    end

    // Working divisor loads on low byte write
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            div_q <= DIV_W'(ubl_pkg::RST_BDL);
        else if (wr_bdl)
            div_q <= div_new;
    end

    // Generator stays off until first enable
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            armed_q <= 1'b0;
        else if (arm_set)
            armed_q <= 1'b1;
    end

    // Read data one cycle after strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n)
            rdata_q <= 8'h00;
        else
            rdata_q <= reg_rd ? rd_mux : 8'h00;
    end

    // Interrupt requests gated by enables
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            brk_irq_q  <= 1'b0;
            edge_irq_q <= 1'b0;
        end else begin
            brk_irq_q  <= break_detect_flag && bdh_q[ubl_pkg::BDH_BRK_IE];
            edge_irq_q <= rx_edge_flag && bdh_q[ubl_pkg::BDH_EDGE_IE];
        end
    end

    ubl_rate_gen #(
        .DIV_W (DIV_W),
        .OSR   (OSR)
    ) u_rate_gen (
        .clk     (clk),
        .reset_n (reset_n),
        .cfg     (cfg)
    );

    ubl_pin_route u_pin_route (
        .clk       (clk),
        .reset_n   (reset_n),
        .cfg       (cfg),
        .tx_serial (tx_serial),
        .tx_drive  (tx_drive),
        .rxd_i     (rxd_i),
        .txd_i     (txd_i),
        .txd_o     (txd_o),
        .txd_oe    (txd_oe),
        .rx_serial (rx_serial)
    );

    property p_div_load;
        @(posedge clk) disable iff (!reset_n)
        wr_bdl |=> div_q == {$past(bdh_q[4:0]), $past(reg_wdata)};
    endproperty
    a_div_load: assert property (p_div_load) else $error("divisor not loaded");

    property p_div_hold;
        @(posedge clk) disable iff (!reset_n)
        (reg_wr && reg_addr != ubl_pkg::OFS_BDL) |=> $stable(div_q);
    endproperty
    a_div_hold: assert property (p_div_hold) else $error("divisor changed early");

    property p_hi_buffer;
        @(posedge clk) disable iff (!reset_n)
        wr_bdh ##1 wr_bdl |=> div_q[12:8] == $past(reg_wdata[4:0], 2);
    endproperty
    a_hi_buffer: assert property (p_hi_buffer) else $error("high bits lost");

    property p_zero_off;
        @(posedge clk) disable iff (!reset_n)
        (div_zero && $past(div_zero)) |-> !baud_tick_16x && !baud_bit_tick;
    endproperty
    a_zero_off: assert property (p_zero_off) else $error("tick with zero divisor");

    property p_unarmed;
        @(posedge clk) disable iff (!reset_n)
        !armed_q |=> !baud_tick_16x;
    endproperty
    a_unarmed: assert property (p_unarmed) else $error("tick before enable");

    property p_arm;
        @(posedge clk) disable iff (!reset_n)
        arm_set |=> armed_q ##1 armed_q;
    endproperty
    a_arm: assert property (p_arm) else $error("enable did not arm");

    property p_brk_irq;
        @(posedge clk) disable iff (!reset_n)
        (break_detect_flag && bdh_q[7]) |=> break_irq;
    endproperty
    a_brk_irq: assert property (p_brk_irq) else $error("break irq missing");

    property p_brk_mask;
        @(posedge clk) disable iff (!reset_n)
        !bdh_q[7] |=> !break_irq;
    endproperty
    a_brk_mask: assert property (p_brk_mask) else $error("break irq not masked");

    property p_edge_irq;
        @(posedge clk) disable iff (!reset_n)
        ##1 rx_edge_irq == $past(rx_edge_flag && bdh_q[6]);
    endproperty
    a_edge_irq: assert property (p_edge_irq) else $error("edge irq wrong");

    property p_stop;
        @(posedge clk) disable iff (!reset_n)
        wr_bdh |=> stop_bit_count_select == $past(reg_wdata[5]);
    endproperty
    a_stop: assert property (p_stop) else $error("stop select wrong");

    property p_bit_tick;
        @(posedge clk) disable iff (!reset_n)
        baud_bit_tick |-> baud_tick_16x;
    endproperty
    a_bit_tick: assert property (p_bit_tick) else $error("bit tick off grid");

    property p_rdata;
        @(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr == ubl_pkg::OFS_C1) |=> reg_rdata == $past(c1_q);
    endproperty
    a_rdata: assert property (p_rdata) else $error("read data wrong");

    property p_div_read;
        @(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr == ubl_pkg::OFS_BDL) |=> reg_rdata == $past(div_q[7:0]);
    endproperty
    a_div_read: assert property (p_div_read) else $error("low byte read wrong");

    property p_zero_tick;
        @(posedge clk) disable iff (!reset_n)
        div_zero |=> !baud_tick_16x;
    endproperty
    a_zero_tick: assert property (p_zero_tick) else $error("tick after zero divisor");

    property p_unarmed_bit;
        @(posedge clk) disable iff (!reset_n)
        !armed_q |=> !baud_bit_tick;
    endproperty
    a_unarmed_bit: assert property (p_unarmed_bit) else $error("bit tick before enable");

    property p_arm_sticky;
        @(posedge clk) disable iff (!reset_n)
        armed_q |=> armed_q;
    endproperty
    a_arm_sticky: assert property (p_arm_sticky) else $error("generator disarmed");

    property p_no_freeze;
        @(posedge clk) disable iff (!reset_n)
        !c1_q[ubl_pkg::C1_FREEZE] |-> !cfg.hold;
    endproperty
    a_no_freeze: assert property (p_no_freeze) else $error("frozen without select");

    property p_stop_keep;
        @(posedge clk) disable iff (!reset_n)
        !wr_bdh |=> $stable(stop_bit_count_select);
    endproperty
    a_stop_keep: assert property (p_stop_keep) else $error("stop select drifted");

    property p_edge_on;
        @(posedge clk) disable iff (!reset_n)
        (rx_edge_flag && bdh_q[ubl_pkg::BDH_EDGE_IE]) |=> rx_edge_irq;
    endproperty
    a_edge_on: assert property (p_edge_on) else $error("edge irq missing");

    property p_edge_mask;
        @(posedge clk) disable iff (!reset_n)
        !bdh_q[ubl_pkg::BDH_EDGE_IE] |=> !rx_edge_irq;
    endproperty
    a_edge_mask: assert property (p_edge_mask) else $error("edge irq not masked");

    property p_brk_idle;
        @(posedge clk) disable iff (!reset_n)
        !break_detect_flag |=> !break_irq;
    endproperty
    a_brk_idle: assert property (p_brk_idle) else $error("break irq without flag");

    property p_loop_sel;
        @(posedge clk) disable iff (!reset_n)
        wr_c1 |=> cfg.loop_routing_select == $past(reg_wdata[ubl_pkg::C1_LOOP]);
    endproperty
    a_loop_sel: assert property (p_loop_sel) else $error("loop select wrong");

    property p_src_sel;
        @(posedge clk) disable iff (!reset_n)
        wr_c1 |=> cfg.receiver_source_select == $past(reg_wdata[ubl_pkg::C1_RXSRC]);
    endproperty
    a_src_sel: assert property (p_src_sel) else $error("source select wrong");

    property p_bdh_read;
        @(posedge clk) disable iff (!reset_n)
        (reg_rd && reg_addr == ubl_pkg::OFS_BDH) |=> reg_rdata == $past(bdh_q);
    endproperty
    a_bdh_read: assert property (p_bdh_read) else $error("high byte read wrong");
endmodule : ubl_top

// File: verif/ubl_remote_model.sv
`timescale 1ns/1ps
module ubl_remote_model (
    input  wire logic rx_bit,
    input  wire logic line_en,
    input  wire logic line_bit,
    input  wire logic txd_o,
    input  wire logic txd_oe,
    output logic      rxd_i,
    output logic      txd_i
);
    // Remote sender on the rx pin
    assign rxd_i = rx_bit;
    // Shared tx wire with pull-up, device drive first
    assign txd_i = txd_oe ? txd_o : (line_en ? line_bit : 1'b1);
endmodule : ubl_remote_model

// File: verif/ubl_top_tb_top.sv
`timescale 1ns/1ps
module ubl_top_tb_top;
    logic       clk, reset_n, reg_wr, reg_rd, cpu_wait, brk_f, edge_f;
    logic       tx_serial, tx_drive, rx_bit, line_en, line_bit, rxd_i, txd_i;
    logic       txd_o, txd_oe, rx_serial, tick, btick, stop2, rx_en, tx_en, brk_irq, edge_irq;
    logic [3:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata, d;
    int         n, n_fail, n_tests;

    ubl_top ubl_top_inst (.clk(clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .cpu_wait(cpu_wait), .break_detect_flag(brk_f), .rx_edge_flag(edge_f),
        .tx_serial(tx_serial), .tx_drive(tx_drive), .rxd_i(rxd_i), .txd_i(txd_i),
        .txd_o(txd_o), .txd_oe(txd_oe), .rx_serial(rx_serial), .baud_tick_16x(tick),
        .baud_bit_tick(btick), .stop_bit_count_select(stop2), .receiver_enable(rx_en),
        .transmitter_enable(tx_en), .break_irq(brk_irq), .rx_edge_irq(edge_irq));

    ubl_remote_model ubl_remote_model_inst (.rx_bit(rx_bit), .line_en(line_en),
        .line_bit(line_bit), .txd_o(txd_o), .txd_oe(txd_oe), .rxd_i(rxd_i), .txd_i(txd_i));

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= v;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr

    // High then low divisor byte, strobe held across both
    task automatic wr_div(input logic [7:0] hi, input logic [7:0] lo);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= 4'h0;
        reg_wdata <= hi;
        @(posedge clk);
        reg_addr  <= 4'h1;
        reg_wdata <= lo;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : wr_div

    task automatic rd(input logic [3:0] a, output logic [7:0] v);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1;
        v = reg_rdata;
    endtask : rd

    // Cycles to the next pulse, -1 if none within lim
    task automatic wait_on(input bit bit_tick, input int lim, output int cnt);
        cnt = -1;
        for (int i = 1; i <= lim; i++) begin
            @(posedge clk);
            #1;
            if ((bit_tick ? btick : tick) === 1'b1) begin
                cnt = i;
                break;
            end
        end
    endtask : wait_on

    task automatic period(input bit bit_tick, input int lim, input int exp);
        wait_on(bit_tick, lim, n);
        wait_on(bit_tick, lim, n);
        chk("tick period", 16'(exp), 16'(n));
    endtask : period

    task automatic t_reset;
        @(posedge clk);
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(4'h0, d);
        chk("bdh", 16'(ubl_pkg::RST_BDH), 16'(d));
        rd(4'h1, d);
        chk("bdl", 16'(ubl_pkg::RST_BDL), 16'(d));
        rd(4'h2, d);
        chk("c1", 16'(ubl_pkg::RST_C1), 16'(d));
        rd(4'h3, d);
        chk("c2", 16'(ubl_pkg::RST_C2), 16'(d));
        rd(4'h7, d);
        chk("unmapped", 16'h0000, 16'(d));
        wait_on(1'b0, 40, n);
        chk("unarmed", 16'hFFFF, 16'(n));
    endtask : t_reset

    task automatic t_divisor;
        wr_div(8'hE0, 8'h03);
        wr(4'h3, 8'h08);
        period(1'b0, 20, 3);
        chk("stop bits", 16'h0001, 16'(stop2));
        chk("tx enable bit", 16'h0001, 16'(tx_en));
        chk("rx enable bit", 16'h0000, 16'(rx_en));
        period(1'b1, 120, 48);
        wr(4'h0, 8'h01);
        period(1'b0, 20, 3);
        rd(4'h1, d);
        chk("bdl held", 16'h0003, 16'(d));
        wr(4'h1, 8'h00);
        period(1'b0, 600, 256);
        wr_div(8'h01, 8'h05);
        period(1'b0, 600, 261);
    endtask : t_divisor

    task automatic t_zero_freeze;
        wr_div(8'h00, 8'h00);
        repeat (2) @(posedge clk);
        wait_on(1'b0, 60, n);
        chk("zero divisor", 16'hFFFF, 16'(n));
        wr(4'h1, 8'h02);
        period(1'b0, 20, 2);
        @(posedge clk) cpu_wait <= 1'b1;
        wr(4'h2, 8'h40);
        repeat (2) @(posedge clk);
        wait_on(1'b0, 30, n);
        chk("frozen", 16'hFFFF, 16'(n));
        wr(4'h2, 8'h00);
        period(1'b0, 20, 2);
        @(posedge clk) cpu_wait <= 1'b0;
    endtask : t_zero_freeze

    task automatic t_irq;
        logic [1:0] en;
        @(posedge clk);
        brk_f  <= 1'b1;
        edge_f <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            en = 2'(i);
            wr(4'h0, {en, 6'h00});
            repeat (2) @(posedge clk);
            chk("break irq", 16'(en[1]), 16'(brk_irq));
            chk("edge irq", 16'(en[0]), 16'(edge_irq));
        end
        @(posedge clk);
        brk_f  <= 1'b0;
        edge_f <= 1'b0;
        repeat (2) @(posedge clk);
        chk("irq idle", 16'h0000, 16'({brk_irq, edge_irq}));
    endtask : t_irq

    task automatic route(input logic [7:0] c1, input logic [4:0] pins, input logic [1:0] exp);
        wr(4'h2, c1);
        @(posedge clk);
        {rx_bit, line_en, line_bit, tx_serial, tx_drive} <= pins;
        repeat (3) @(posedge clk);
        chk("rx serial", 16'(exp[1]), 16'(rx_serial));
        chk("tx enable", 16'(exp[0]), 16'(txd_oe));
        chk("tx pin", 16'(pins[1]), 16'(txd_o));
    endtask : route

    task automatic t_route;
        route(8'h00, 5'b00110, 2'b01);
        route(8'h80, 5'b10001, 2'b01);
        route(8'h80, 5'b00110, 2'b11);
        route(8'hA0, 5'b11010, 2'b00);
        route(8'hA0, 5'b00011, 2'b11);
    endtask : t_route

    task automatic conclude;
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : conclude

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        conclude();
    end

    initial begin
        n_fail    = 0;
        n_tests   = 0;
        reset_n   = 1'b0;
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 4'h0;
        reg_wdata = 8'h00;
        cpu_wait  = 1'b0;
        brk_f     = 1'b0;
        edge_f    = 1'b0;
        tx_serial = 1'b1;
        tx_drive  = 1'b0;
        rx_bit    = 1'b1;
        line_en   = 1'b0;
        line_bit  = 1'b1;
        t_reset();
        t_divisor();
        t_zero_freeze();
        t_irq();
        t_route();
        t_reset();
        conclude();
    end
endmodule : ubl_top_tb_top
